// file: pkg/sesa_pkg.sv
/*
  Shared constants and types for the serial EEPROM slave access block.
  Assumes a 25 MHz system clock and a two-wire bus sampled by that clock.
*/
package sesa_pkg;
  localparam int ADDR_W        = 11;
  localparam int BLK_W         = 3;
  localparam int OFS_W         = 5;
  localparam int PAGE_W        = 6;
  localparam int BYTE_W        = 8;
  localparam int CNT_W         = 4;
  localparam int MEM_DEPTH     = 2048;
  localparam int PAGE_BYTES    = 32;
  localparam int CMT_W         = 6;
  localparam int EW_CNT_W      = 18;
  localparam int POR_CNT_W     = 8;
  localparam int CLK_PERIOD_NS = 40;
  localparam int EW_TIME_MS    = 10;
  localparam int POR_TIME_US   = 10;
  // longest times, rounded down to whole cycles
  localparam int EW_CYC_DFLT   = EW_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POR_CYC       = POR_TIME_US * 1000 / CLK_PERIOD_NS;

  localparam logic [CNT_W-1:0]     BIT_LAST  = 4'h8;
  localparam logic [CNT_W-1:0]     BIT_ZERO  = 4'h0;
  localparam logic [ADDR_W-1:0]    ADDR_LAST = 11'h7FF;
  localparam logic [ADDR_W-1:0]    ADDR_RST  = 11'h000;
  localparam logic [OFS_W-1:0]     OFS_LAST  = 5'h1F;
  localparam logic [PAGE_BYTES-1:0] MASK_RST = 32'h0000_0000;
  localparam logic [POR_CNT_W-1:0] POR_LAST  = POR_CNT_W'(POR_CYC - 1);

  typedef enum logic [3:0] {
    S_IDLE, S_DEV, S_ACK_DEV, S_WORD, S_ACK_WORD,
    S_WDATA, S_ACK_DATA, S_RDATA, S_MACK, S_WAIT
  } sesa_state_t;

  typedef struct packed {
    logic [3:0]       type_id;
    logic [BLK_W-1:0] blk;
    logic             rd;
  } sesa_slv_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
  } sesa_pins_t;
endpackage : sesa_pkg

// file: core/sesa_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous pin levels.
  Assumes the inputs are quasi-static compared with the sampling clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sesa_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // levels
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '1;
      q        <= '1;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : sesa_sync
`default_nettype wire

// file: core/sesa_eeprom.sv
/*
  Two-wire bus slave EEPROM core: address decode, page write with timed
  commit, write protect and auto-incrementing reads over a 2048-byte array.
  Assumes SCL, SDA and WP arrive asynchronously and SDA is open drain outside.
*/
`timescale 1ns/1ns
`default_nettype none
module sesa_eeprom #(
  parameter logic [3:0]  TYPE_ID   = 4'h5,  // arbitrary type identifier
  parameter int unsigned EW_CYCLES = sesa_pkg::EW_CYC_DFLT
) (
  // clock and reset
  input  wire logic MCLK,
  input  wire logic RST_B,
  // two-wire bus
  input  wire logic SCL,
  input  wire logic SDA_I,
  output var  logic SDA_O,
  output var  logic SDA_OE,
  // write protect and status
  input  wire logic WP,
  output var  logic BUSY
);
  import sesa_pkg::*;

  localparam logic [EW_CNT_W-1:0] EW_LAST = EW_CNT_W'(EW_CYCLES - 1);

  sesa_pins_t           pin_s;
  logic                 scl_d_reg;
  logic                 sda_d_reg;
  sesa_state_t          state_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic [BYTE_W-1:0]    shift_reg;
  logic [BYTE_W-1:0]    tx_reg;
  logic [ADDR_W-1:0]    addr_reg;
  logic                 rd_reg;
  logic                 mack_reg;
  logic                 sda_oe_reg;
  logic                 got_reg;
  logic [PAGE_BYTES-1:0] mask_reg;
  logic [BYTE_W-1:0]    page_buf [PAGE_BYTES];
  logic [BYTE_W-1:0]    mem [MEM_DEPTH];
  logic                 busy_reg;
  logic [EW_CNT_W-1:0]  ew_cnt_reg;
  logic [CMT_W-1:0]     cmt_reg;
  logic [PAGE_W-1:0]    page_reg;
  logic [POR_CNT_W-1:0] por_cnt_reg;
  logic                 por_done_reg;

  sesa_slv_t            slv;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_det;
  logic                 stop_det;
  logic                 live;
  logic                 byte_done;
  logic                 dev_take;
  logic                 word_take;
  logic                 data_take;
  logic                 rd_done;
  logic                 ew_go;
  logic                 ew_end;
  logic [ADDR_W-1:0]    rd_idx;
  logic [BYTE_W-1:0]    rd_byte;

  sesa_sync #(.W(3)) u_sync (
    .clk   (MCLK),
    .rst_b (RST_B),
    .d     ({SCL, SDA_I, WP}),
    .q     (pin_s)
  );

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= pin_s.scl;
      sda_d_reg <= pin_s.sda;
    end
  end

  assign slv       = sesa_slv_t'(shift_reg);
  assign scl_rise  = pin_s.scl & ~scl_d_reg;
  assign scl_fall  = ~pin_s.scl & scl_d_reg;
  assign start_det = pin_s.scl & scl_d_reg & sda_d_reg & ~pin_s.sda;
  assign stop_det  = pin_s.scl & scl_d_reg & ~sda_d_reg & pin_s.sda;
  assign live      = por_done_reg & ~busy_reg & ~start_det & ~stop_det;
  assign byte_done = live & scl_fall & (cnt_reg == BIT_LAST);
  assign dev_take  = byte_done & (state_reg == S_DEV) & (slv.type_id == TYPE_ID);
  assign word_take = byte_done & (state_reg == S_WORD);
  assign data_take = byte_done & (state_reg == S_WDATA) & ~pin_s.wp;
  assign rd_done   = byte_done & (state_reg == S_RDATA);
  assign ew_go     = stop_det & por_done_reg & ~busy_reg & got_reg;
  assign ew_end    = busy_reg & (ew_cnt_reg == EW_LAST);
  // a current address read takes the block from the new slave address
  assign rd_idx    = (state_reg == S_DEV) ? {slv.blk, addr_reg[BYTE_W-1:0]} : addr_reg;
  assign rd_byte   = mem[rd_idx];
  assign SDA_O     = 1'b0;
  assign SDA_OE    = sda_oe_reg;
  assign BUSY      = busy_reg;

  // power-on reset keeps the bus logic idle for its set-up time
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      por_cnt_reg  <= '0;
      por_done_reg <= 1'b0;
    end
    else if (!por_done_reg)
    begin
      por_cnt_reg  <= por_cnt_reg + 1'b1;
      por_done_reg <= (por_cnt_reg == POR_LAST);
    end
  end

  // bus protocol state and SDA drive
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_reg  <= S_IDLE;
      cnt_reg    <= BIT_ZERO;
      shift_reg  <= '0;
      tx_reg     <= '0;
      rd_reg     <= 1'b0;
      mack_reg   <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (!por_done_reg || busy_reg)
    begin
      state_reg  <= S_IDLE;
      sda_oe_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg  <= S_DEV;
      cnt_reg    <= BIT_ZERO;
      sda_oe_reg <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg  <= S_IDLE;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        S_DEV, S_WORD, S_WDATA:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[BYTE_W-2:0], pin_s.sda};
            cnt_reg   <= cnt_reg + 1'b1;
          end
          else if (byte_done)
          begin
            cnt_reg <= BIT_ZERO;
            if (state_reg == S_DEV)
            begin
              state_reg  <= dev_take ? S_ACK_DEV : S_IDLE;
              sda_oe_reg <= dev_take;
              rd_reg     <= slv.rd;
              tx_reg     <= rd_byte;
            end
            else if (state_reg == S_WORD)
            begin
              state_reg  <= S_ACK_WORD;
              sda_oe_reg <= 1'b1;
            end
            else
            begin
              state_reg  <= S_ACK_DATA;
              sda_oe_reg <= ~pin_s.wp;
            end
          end
        end
        S_ACK_DEV:
          if (scl_fall)
          begin
            state_reg  <= rd_reg ? S_RDATA : S_WORD;
            sda_oe_reg <= rd_reg & ~tx_reg[BYTE_W-1];
          end
        S_ACK_WORD, S_ACK_DATA:
          if (scl_fall)
          begin
            state_reg  <= S_WDATA;
            sda_oe_reg <= 1'b0;
          end
        S_RDATA:
          if (scl_rise)
            cnt_reg <= cnt_reg + 1'b1;
          else if (byte_done)
          begin
            state_reg  <= S_MACK;
            cnt_reg    <= BIT_ZERO;
            sda_oe_reg <= 1'b0;
          end
          else if (scl_fall)
          begin
            sda_oe_reg <= ~tx_reg[BYTE_W-2];
            tx_reg     <= {tx_reg[BYTE_W-2:0], 1'b0};
          end
        S_MACK:
          if (scl_rise)
            mack_reg <= ~pin_s.sda;
          else if (scl_fall)
          begin
            // keep sending while the master acknowledges
            state_reg  <= mack_reg ? S_RDATA : S_WAIT;
            tx_reg     <= rd_byte;
            sda_oe_reg <= mack_reg & ~rd_byte[BYTE_W-1];
          end
        S_IDLE, S_WAIT:
          sda_oe_reg <= 1'b0;
        default:
        begin
          state_reg  <= S_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // internal address counter
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      addr_reg <= ADDR_RST;
    else if (dev_take)
      addr_reg[ADDR_W-1 -: BLK_W] <= slv.blk;
    else if (word_take)
      addr_reg[BYTE_W-1:0] <= shift_reg;
    else if (data_take)
      addr_reg[OFS_W-1:0] <= addr_reg[OFS_W-1:0] + 1'b1;
    else if (rd_done)
      addr_reg <= addr_reg + 1'b1;
  end

  // page buffer collects data bytes until STOP
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      mask_reg <= MASK_RST;
      got_reg  <= 1'b0;
    end
    else if (ew_end || (start_det && !busy_reg))
    begin
      mask_reg <= MASK_RST;
      got_reg  <= 1'b0;
    end
    else if (data_take)
    begin
      mask_reg[addr_reg[OFS_W-1:0]] <= 1'b1;
      got_reg                       <= 1'b1;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (data_take)
      page_buf[addr_reg[OFS_W-1:0]] <= shift_reg;
  end

  // timed erase/write cycle, committing one buffered byte per clock
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      busy_reg   <= 1'b0;
      ew_cnt_reg <= '0;
      cmt_reg    <= '0;
      page_reg   <= '0;
    end
    else if (ew_go)
    begin
      busy_reg   <= 1'b1;
      ew_cnt_reg <= '0;
      cmt_reg    <= '0;
      page_reg   <= addr_reg[ADDR_W-1:OFS_W];
    end
    else if (busy_reg)
    begin
      ew_cnt_reg <= ew_cnt_reg + 1'b1;
      busy_reg   <= ~ew_end;
      if (!cmt_reg[CMT_W-1])
        cmt_reg <= cmt_reg + 1'b1;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (busy_reg && !cmt_reg[CMT_W-1] && mask_reg[cmt_reg[OFS_W-1:0]])
      mem[{page_reg, cmt_reg[OFS_W-1:0]}] <= page_buf[cmt_reg[OFS_W-1:0]];
  end

  chk_busy_no_ack: assert property (@(posedge MCLK) disable iff (!RST_B)
    busy_reg |-> !SDA_OE)
    else $error("SDA driven during erase/write cycle");

  chk_stop_starts_ew: assert property (@(posedge MCLK) disable iff (!RST_B)
    ew_go |=> busy_reg [*8])
    else $error("erase/write cycle did not start on STOP");

  chk_ew_bounded: assert property (@(posedge MCLK) disable iff (!RST_B)
    busy_reg |-> ew_cnt_reg <= EW_LAST)
    else $error("erase/write cycle exceeds its maximum");

  chk_empty_stop_idle: assert property (@(posedge MCLK) disable iff (!RST_B)
    (stop_det && !got_reg && !busy_reg) |=> !busy_reg)
    else $error("write cycle started with no data");

  chk_id_mismatch: assert property (@(posedge MCLK) disable iff (!RST_B)
    (byte_done && state_reg == S_DEV && slv.type_id != TYPE_ID) |=>
      (state_reg == S_IDLE && !SDA_OE))
    else $error("acknowledged a foreign type identifier");

  chk_addr_ack: assert property (@(posedge MCLK) disable iff (!RST_B)
    (dev_take || word_take) |=>
      (SDA_OE && (state_reg == S_ACK_DEV || state_reg == S_ACK_WORD)))
    else $error("address byte not acknowledged");

  chk_wp_nack: assert property (@(posedge MCLK) disable iff (!RST_B)
    (byte_done && state_reg == S_WDATA && pin_s.wp) |=>
      (!SDA_OE && $stable(mask_reg) && state_reg == S_ACK_DATA))
    else $error("protected data byte acknowledged or stored");

  chk_page_wrap: assert property (@(posedge MCLK) disable iff (!RST_B)
    (data_take && addr_reg[OFS_W-1:0] == OFS_LAST) |=>
      (addr_reg[OFS_W-1:0] == '0 && $stable(addr_reg[ADDR_W-1:OFS_W])))
    else $error("page write address left its page");

  chk_read_roll: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_done && addr_reg == ADDR_LAST) |=> addr_reg == ADDR_RST)
    else $error("read address did not roll over");

  chk_por_idle: assert property (@(posedge MCLK) disable iff (!RST_B)
    !por_done_reg |=> (state_reg == S_IDLE && !SDA_OE))
    else $error("bus logic active during power-on reset");
endmodule : sesa_eeprom
`default_nettype wire

// file: tb/sesa_master.sv
/*
  Two-wire bus master model that drives the EEPROM slave.
  Assumes a 40 ns clock; SCL period is 8 clocks and SCL idles high between frames.
*/
`timescale 1ns/1ns
`default_nettype none
module sesa_master (
  // clock
  input  wire logic clk,
  // device side of the data line
  input  wire logic dev_oe,
  input  wire logic dev_o,
  // bus lines
  output var  logic scl,
  output wire logic sda
);
  logic sda_m;
  // pull-up: the line is low when either party pulls it
  assign sda = (dev_oe ? dev_o : 1'b1) & sda_m;
  initial
  begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  task automatic q();
    repeat (2) @(posedge clk);
    #1;
  endtask : q
  task automatic bitx(input logic b, output logic s);
    sda_m = b;
    q();
    scl = 1'b1;
    q();
    s = sda;
    q();
    scl = 1'b0;
    q();
  endtask : bitx
  // extra wait lets the device let go of an ack before a repeated start
  task automatic start();
    sda_m = 1'b1;
    q();
    q();
    scl = 1'b1;
    q();
    sda_m = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask : start
  task automatic stop();
    sda_m = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_m = 1'b1;
    q();
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(~more, s);
  endtask : rbyte
endmodule : sesa_master
`default_nettype wire

// file: tb/sesa_eeprom_bench.sv
/*
  Self-checking bench for the EEPROM slave: writes, reads, protect and busy.
  Assumes the master model in sesa_master and a short erase/write count.
*/
`timescale 1ns/1ns
`default_nettype none
module sesa_eeprom_bench;
  import sesa_pkg::*;
  localparam logic [3:0] TID = 4'h5; // arbitrary type identifier
  logic        MCLK;
  logic        RST_B;
  logic        WP;
  logic        SDA_O;
  logic        SDA_OE;
  logic        BUSY;
  logic        scl;
  wire logic   sda;
  logic [7:0]  exp_mem [0:MEM_DEPTH-1];
  logic [31:0] lf = 32'h843C4315;
  int          n_fail = 0;
  int          tests_run = 0;
  sesa_eeprom #(.TYPE_ID(TID), .EW_CYCLES(160)) i_dut (.MCLK(MCLK), .RST_B(RST_B),
    .SCL(scl), .SDA_I(sda), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .WP(WP), .BUSY(BUSY));
  sesa_master i_mst (.clk(MCLK), .dev_oe(SDA_OE), .dev_o(SDA_O), .scl(scl), .sda(sda));
  initial
  begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction : rnd
  // write address: page fixed, offset wraps
  function automatic logic [10:0] wadr(input logic [10:0] a, input int i);
    return {a[10:5], a[4:0] + 5'(i)};
  endfunction : wadr
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic sel(input logic [3:0] id, input logic [10:0] a, input logic r,
                     output logic k);
    i_mst.start();
    i_mst.wbyte({id, a[10:8], r}, k);
  endtask : sel
  task automatic wr(input logic [10:0] a, input int n, input logic p);
    logic       k;
    logic [7:0] d;
    int         t;
    WP = p;
    sel(TID, a, 1'b0, k);
    chk(8'(k), 8'h01);
    i_mst.wbyte(a[7:0], k);
    chk(8'(k), 8'h01);
    for (int i = 0; i < n; i++)
    begin
      d = rnd();
      i_mst.wbyte(d, k);
      chk(8'(k), 8'(!p));
      if (!p)
        exp_mem[wadr(a, i)] = d;
    end
    i_mst.stop();
    repeat (4) @(posedge MCLK);
    #1;
    chk(8'(BUSY), 8'(n > 0 && !p));
    if (BUSY === 1'b1)
    begin
      sel(TID, a, 1'b0, k);
      chk(8'(k), 8'h00);
      i_mst.stop();
    end
    t = 0;
    while (BUSY !== 1'b0 && t < 400)
    begin
      @(posedge MCLK);
      t++;
    end
    #1;
    chk(8'(BUSY), 8'h00);
  endtask : wr
  task automatic rd(input logic [10:0] a, input int n, input logic ld);
    logic       k;
    logic [7:0] d;
    if (ld)
    begin
      sel(TID, a, 1'b0, k);
      i_mst.wbyte(a[7:0], k);
    end
    sel(TID, a, 1'b1, k);
    chk(8'(k), 8'h01);
    for (int i = 0; i < n; i++)
    begin
      i_mst.rbyte(i < n - 1, d);
      chk(d, exp_mem[11'(a + i)]);
    end
    i_mst.stop();
    chk(8'(SDA_OE), 8'h00);
  endtask : rd
  initial
  begin
    logic        k;
    logic [7:0]  d;
    logic [10:0] a;
    RST_B = 1'b0;
    WP = 1'b0;
    repeat (3) @(posedge MCLK);
    #1;
    chk(8'({SDA_OE, BUSY}), 8'h00);
    RST_B = 1'b1;
    sel(TID, 11'h000, 1'b0, k);
    chk(8'(k), 8'h00);
    i_mst.stop();
    repeat (300) @(posedge MCLK);
    for (int i = 0; i < 4; i++)
    begin
      sel(TID ^ (4'h1 << i), 11'h000, 1'b0, k);
      chk(8'(k), 8'h00);
      i_mst.stop();
    end
    d = rnd();
    a = {d[5:0], 5'h1E};
    wr(a, 32, 1'b0);
    rd(a, 32, 1'b1);
    repeat (4)
    begin
      d = rnd();
      a[10:8] = d[2:0];
      a[7:0] = rnd();
      d = rnd();
      wr(a, int'(d[4:0]) + 1, 1'b0);
      rd({a[10:5], 5'h00}, 32, 1'b1);
    end
    // read rollover at the top of the array, then a current address read
    wr(11'h7FE, 2, 1'b0);
    wr(11'h000, 2, 1'b0);
    rd(11'h7FE, 3, 1'b1);
    rd(11'h001, 1, 1'b0);
    wr(11'h7FE, 2, 1'b1);
    rd(11'h7FE, 2, 1'b1);
    wr(11'h123, 0, 1'b0);
    stop_test();
  end
  initial
  begin
    repeat (90000) @(posedge MCLK);
    n_fail++;
    $display("watchdog expired at %0t", $time);
    stop_test();
  end
endmodule : sesa_eeprom_bench
`default_nettype wire
